// file: shared/digipot_pkg.sv
// Package with constants and types for the digipot serial command unit.
package digipot_pkg;

  // ==========================================================================
  // Frame layout
  localparam int          FRAME_BITS      = 16;
  localparam int          CNT_W           = 4;
  localparam int          CHANNELS        = 2;
  localparam int          CMD_SEL_LO_POS  = 4;
  localparam int          CMD_SEL_HI_POS  = 5;
  localparam int          CH0_SEL_POS     = 0;
  localparam int          CH1_SEL_POS     = 1;

  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0]  WIPER_MIDSCALE  = 8'h80;
  localparam logic [1:0]  CODE_WRITE      = 2'h1;
  localparam logic [1:0]  CODE_SHUTDOWN   = 2'h2;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CMD_NOP,
    CMD_WRITE,
    CMD_SHUTDOWN
  } cmd_t;

  typedef struct packed {
    logic [7:0] command;
    logic [7:0] data;
  } frame_t;

  typedef struct packed {
    logic [7:0] wiper1;
    logic [7:0] wiper0;
  } wipers_t;

endpackage

// file: design/digipot_serial_command_unit.sv
// Serial command front end of a dual-channel digital potentiometer.
`timescale 1ns/1ps
// Function
// - Three commands exist: write wipers, shutdown channels, no operation.
// - Commands execute only when chip select rises, never mid-frame.
// - Input sampled on rising serial clock, output changes on falling edge.
// - Rising edges counted while selected; non-multiple of sixteen aborts.
// - First frame byte is command, second byte is data.
// - Unused command byte bits are ignored.
// - Command code at bits 5:4; equal bits give no operation.
// - Code 0,1 writes data byte into each selected wiper register.
// - Code 1,0 puts each selected channel into shutdown.
// - Bits 1:0 select channels; zero leaves a channel unchanged.
// - Code 00h is wiper at B, rising codes move toward A.
// - Wipers go mid-scale at power-up and on the reset pin while chip select is high.
// - Mid-scale value is 80h.
// - Shutdown opens A, ties wiper to B, keeps stored wiper codes.
// - Serial output always driven, low while chip select is high.
module digipot_serial_command_unit
  import digipot_pkg::*;
(
  input  wire logic                clock,                    // 50 MHz system clock
  input  wire logic                rstn,                     // Async power-on reset, low
  input  wire logic                cs_n,                     // Chip select pin, low active
  input  wire logic                sck,                      // Serial clock pin
  input  wire logic                sdi,                      // Serial data in pin
  input  wire logic                wiper_midscale_reset_pin, // Reset pin, low loads mid-scale while deselected
  input  wire logic                hardware_powerdown_pin,   // Shutdown pin, low forces shutdown
  output logic                     sdo,                      // Serial data out pin
  output logic [7:0]               wiper0_code_q,            // Channel 0 code, 00h at B
  output logic [7:0]               wiper1_code_q,            // Channel 1 code, 00h at B
  output logic [CHANNELS-1:0]      open_a_q,                 // Per channel: A open, W tied to B
  output logic [CHANNELS-1:0]      sw_shutdown_q             // Per channel software shutdown
);

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] cs_s_q, sck_s_q, sdi_s_q, mid_s_q, pd_s_q;
  logic       cs_prev_q, sck_prev_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_s_q     <= 2'h3;
      sck_s_q    <= 2'h0;
      sdi_s_q    <= 2'h0;
      mid_s_q    <= 2'h3;
      pd_s_q     <= 2'h3;
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_s_q     <= {cs_s_q[0], cs_n};
      sck_s_q    <= {sck_s_q[0], sck};
      sdi_s_q    <= {sdi_s_q[0], sdi};
      mid_s_q    <= {mid_s_q[0], wiper_midscale_reset_pin};
      pd_s_q     <= {pd_s_q[0], hardware_powerdown_pin};
      cs_prev_q  <= cs_s_q[1];
      sck_prev_q <= sck_s_q[1];
    end
  end

  // Only stage 1 is read, stage 0 is the metastability catcher.
  logic cs_n_s, sck_rise, sck_fall, cs_rise, midscale_req;
  assign cs_n_s       = cs_s_q[1];
  assign sck_rise     = !cs_n_s && sck_s_q[1] && !sck_prev_q;
  assign sck_fall     = !cs_n_s && !sck_s_q[1] && sck_prev_q;
  assign cs_rise      = cs_n_s && !cs_prev_q;
  assign midscale_req = !mid_s_q[1] && cs_n_s;

  // ==========================================================================
  // Shift register and edge counter
  frame_t             shift_q;
  logic [CNT_W-1:0]   edge_cnt_q;
  logic               any_edge_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q    <= '0;
      edge_cnt_q <= '0;
      any_edge_q <= 1'b0;
    end else if (cs_n_s) begin
      // Cleared while deselected so a daisy chain sees zeros, i.e. a no-op.
      shift_q    <= '0;
      edge_cnt_q <= '0;
      any_edge_q <= 1'b0;
    end else if (sck_rise) begin
      shift_q    <= {shift_q[FRAME_BITS-2:0], sdi_s_q[1]};
      edge_cnt_q <= edge_cnt_q + 4'h1;
      any_edge_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Serial output, push-pull, low while deselected
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdo <= 1'b0;
    end else if (cs_n_s) begin
      sdo <= 1'b0;
    end else if (sck_fall) begin
      sdo <= shift_q[FRAME_BITS-1];
    end
  end

  // ==========================================================================
  // Command decode
  cmd_t             cmd;
  logic [1:0]       code;
  logic [CHANNELS-1:0] ch_sel;
  logic             frame_ok;

  // Only bits 5:4 and 1:0 of the command byte are looked at.
  assign code     = {shift_q.command[CMD_SEL_HI_POS], shift_q.command[CMD_SEL_LO_POS]};
  assign ch_sel   = {shift_q.command[CH1_SEL_POS], shift_q.command[CH0_SEL_POS]};
  assign frame_ok = any_edge_q && (edge_cnt_q == '0);

  always_comb begin
    case (code)
      CODE_WRITE:    cmd = CMD_WRITE;
      CODE_SHUTDOWN: cmd = CMD_SHUTDOWN;
      default:       cmd = CMD_NOP;
    endcase
  end

  // The shift register is cleared one edge after cs_n_s rises, so the decode
  // still sees the complete frame in the cycle in which exec is high.
  logic exec;
  assign exec = cs_rise && frame_ok;

  // ==========================================================================
  // Wiper registers, both channels in one block, each with its own select bit
  wipers_t wipers_q;
  assign wiper0_code_q = wipers_q.wiper0;
  assign wiper1_code_q = wipers_q.wiper1;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wipers_q <= {WIPER_MIDSCALE, WIPER_MIDSCALE};
    end else if (midscale_req) begin
      wipers_q <= {WIPER_MIDSCALE, WIPER_MIDSCALE};
    end else if (exec && cmd == CMD_WRITE) begin
      if (ch_sel[0]) wipers_q.wiper0 <= shift_q.data;
      if (ch_sel[1]) wipers_q.wiper1 <= shift_q.data;
    end
  end

  // ==========================================================================
  // Shutdown states; stored codes are untouched by shutdown
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_shutdown_q <= '0;
    end else if (exec && cmd == CMD_SHUTDOWN) begin
      sw_shutdown_q <= sw_shutdown_q | ch_sel;
    end else if (exec && cmd == CMD_WRITE) begin
      sw_shutdown_q <= sw_shutdown_q & ~ch_sel;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      open_a_q <= '0;
    end else begin
      open_a_q <= sw_shutdown_q | {CHANNELS{!pd_s_q[1]}};
    end
  end

  // ==========================================================================
  // Checks
  chk_nop_keeps_wipers: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_NOP && !midscale_req) |=> $stable(wipers_q))
    else $error("no-op changed a wiper");
  chk_abort_keeps_state: assert property (@(posedge clock) disable iff (!rstn)
    (cs_rise && !frame_ok && !midscale_req) |=> ($stable(wipers_q) && $stable(sw_shutdown_q)))
    else $error("aborted frame changed state");
  chk_write_loads_data: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_WRITE && ch_sel[0] && !midscale_req)
      |=> wipers_q.wiper0 == $past(shift_q.data))
    else $error("write did not load wiper 0");
  chk_unselected_kept: assert property (@(posedge clock) disable iff (!rstn)
    (exec && !ch_sel[1] && !midscale_req) |=> $stable(wipers_q.wiper1))
    else $error("unselected channel changed");
  chk_shutdown_sets: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_SHUTDOWN && ch_sel[0]) |=> sw_shutdown_q[0] ##1 open_a_q[0])
    else $error("shutdown not entered");
  chk_shutdown_keeps_code: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_SHUTDOWN && !midscale_req) |=> $stable(wipers_q))
    else $error("shutdown altered a wiper code");
  chk_sdo_low_idle: assert property (@(posedge clock) disable iff (!rstn)
    cs_n_s |=> !sdo)
    else $error("serial output not low while deselected");
  chk_midscale_load: assert property (@(posedge clock) disable iff (!rstn)
    midscale_req |=> wipers_q == {WIPER_MIDSCALE, WIPER_MIDSCALE})
    else $error("reset pin did not load mid-scale");
  chk_no_exec_mid_frame: assert property (@(posedge clock) disable iff (!rstn)
    (!cs_n_s && !$past(cs_n_s)) |=> $stable(sw_shutdown_q))
    else $error("command acted while selected");
  chk_write_loads_wiper1: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_WRITE && ch_sel[1] && !midscale_req)
      |=> wipers_q.wiper1 == $past(shift_q.data))
    else $error("write did not load wiper 1");
  chk_unselected_ch0_kept: assert property (@(posedge clock) disable iff (!rstn)
    (exec && !ch_sel[0] && !midscale_req) |=> $stable(wipers_q.wiper0))
    else $error("unselected channel 0 changed");
  chk_shutdown_ch1_sets: assert property (@(posedge clock) disable iff (!rstn)
    (exec && cmd == CMD_SHUTDOWN && ch_sel[1]) |=> sw_shutdown_q[1])
    else $error("shutdown not entered on channel 1");
  chk_sdo_shifts_msb: assert property (@(posedge clock) disable iff (!rstn)
    sck_fall |=> sdo == $past(shift_q[FRAME_BITS-1]))
    else $error("serial output did not show the register msb");
  chk_shift_takes_sdi: assert property (@(posedge clock) disable iff (!rstn)
    sck_rise |=> shift_q[0] == $past(sdi_s_q[1]))
    else $error("shift register did not take the input bit");
  chk_pin_opens_a: assert property (@(posedge clock) disable iff (!rstn)
    !pd_s_q[1] |=> open_a_q == {CHANNELS{1'b1}})
    else $error("powerdown pin did not open the A terminals");

  cov_write: cover property (@(posedge clock) disable iff (!rstn) exec && cmd == CMD_WRITE);
  cov_shutdown: cover property (@(posedge clock) disable iff (!rstn)
    exec && cmd == CMD_SHUTDOWN);
  cov_abort: cover property (@(posedge clock) disable iff (!rstn) cs_rise && any_edge_q && !frame_ok);
  cov_nop: cover property (@(posedge clock) disable iff (!rstn) exec && cmd == CMD_NOP);

endmodule

// file: testbench/digipot_host_model.sv
// Host controller model that shifts frames into the serial command unit.
`timescale 1ns/1ps
module digipot_host_model (
  input  wire logic        clock, // Pacing clock
  output logic             cs_n,  // Chip select
  output logic             sck,   // Serial clock, idle low
  output logic             sdi,   // Data to device
  input  wire logic        sdo,   // Data from device
  output logic [31:0]      rx_q   // Bits seen on sdo
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
    rx_q = 32'h0;
  end
  // Half a link period is four system clocks, so the device's synchroniser keeps up.
  task automatic half;
    repeat (4) @(posedge clock);
    #2;
  endtask
  // ==========
  // Frame transfer
  task automatic send(input logic [31:0] bits, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      half();
      sck = 1'b1;
      half();
      rx_q = {rx_q[30:0], sdo};
      sck  = 1'b0;
    end
    half();
    cs_n = 1'b1;
    sdi  = ~sdi; // The released line must not look like held data.
    repeat (2) half();
  endtask
endmodule

// file: testbench/digipot_serial_command_unit_test.sv
// Self-checking bench for the digipot serial command unit.
`timescale 1ns/1ps
module digipot_serial_command_unit_test;
  import digipot_pkg::*;
  logic        clock, rstn, cs_n, sck, sdi, sdo, mid_pin, pdn_pin;
  logic [7:0]  w0, w1, c, d;
  logic [1:0]  open_a, sw_sd;
  logic [31:0] rx;
  logic [17:0] st;
  int          err_total, tests_run, n;

  digipot_serial_command_unit u_digipot_serial_command_unit (.clock(clock), .rstn(rstn),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .wiper_midscale_reset_pin(mid_pin),
    .hardware_powerdown_pin(pdn_pin), .sdo(sdo), .wiper0_code_q(w0), .wiper1_code_q(w1),
    .open_a_q(open_a), .sw_shutdown_q(sw_sd));
  digipot_host_model u_digipot_host_model (.clock(clock), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo(sdo), .rx_q(rx));

  // ==========
  // Expectations and checks
  function automatic logic [17:0] next_exp(logic [17:0] s, logic [7:0] cm, logic [7:0] dt);
    if (cm[5:4] == CODE_WRITE) begin
      if (cm[0]) s = {s[17], 1'b0, s[15:8], dt}; // A write also leaves shutdown.
      if (cm[1]) s = {1'b0, s[16], dt, s[7:0]};
    end else if (cm[5:4] == CODE_SHUTDOWN) begin
      s[17:16] = s[17:16] | cm[1:0];
    end
    return s;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_state;
    check({14'h0, sw_sd, w1, w0}, {14'h0, st});
    check({30'h0, open_a}, {30'h0, st[17:16] | {2{~pdn_pin}}});
    check({31'h0, sdo}, 32'h0);
  endtask
  task automatic send(input logic [31:0] bits, input int k);
    u_digipot_host_model.send(bits, k);
    if (k % 16 == 0) st = next_exp(st, bits[15:8], bits[7:0]);
    check_state();
    if (k == 32) check(rx, {16'h0, bits[31:16]});
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========
  // Clock, watchdog and main sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #1ms;
    err_total++;
    close_out();
  end
  initial begin
    rstn      = 1'b0;
    mid_pin   = 1'b1;
    pdn_pin   = 1'b1;
    err_total = 0;
    tests_run = 0;
    st        = {2'b00, WIPER_MIDSCALE, WIPER_MIDSCALE};
    void'($urandom(63));
    wait_clk(4);
    rstn = 1'b1;
    wait_clk(2);
    check_state();
    for (int i = 0; i < 48; i++) begin
      c       = 8'($urandom);
      d       = 8'($urandom);
      c[5:4]  = 2'(i);
      pdn_pin = ($urandom_range(3) != 0);
      n = (i % 6 == 5) ? 16 * int'($urandom_range(1)) + int'($urandom_range(15, 1)) : 16;
      if (i % 8 == 7) n = 32;
      send({16'($urandom), c, d}, n);
    end
    pdn_pin = 1'b1;
    send({16'h0, 8'h13, 8'hff}, 16);
    send({16'h0, 8'h23, 8'h00}, 17);
    send({16'h0, 8'h13, 8'h00}, 15);
    send({16'h0, 8'h31, 8'h00}, 16);
    mid_pin = 1'b0;
    wait_clk(10);
    mid_pin = 1'b1;
    wait_clk(6);
    st[15:0] = {WIPER_MIDSCALE, WIPER_MIDSCALE};
    check_state();
    close_out();
  end
endmodule
